// ---- verilog/interprocessor_mailbox_pair.sv ----
// top of the mailbox pair: local and remote register ports, frame-aligned
// interrupt delivery and the main-side interrupt reporter.
// assumes access ports, frame strobes and node requests are on clk already.
`timescale 1ns/1ps
module interprocessor_mailbox_pair (
  input wire logic clk,
  input wire logic rstn,
  input mailbox_pkg::bus_request_type local_request,
  output logic [7:0] local_rdata,
  output logic local_ack,
  input mailbox_pkg::bus_request_type remote_request,
  output logic [7:0] remote_rdata,
  output logic remote_ack,
  input wire logic downstream_control_frame,
  input wire logic upstream_response_frame,
  input wire logic upstream_ack,
  output logic interrupt_request_pin,
  output logic upstream_irq_request,
  output logic [7:0] upstream_irq_type,
  input wire logic [mailbox_pkg::NODES-1:0] node_request,
  input wire logic [mailbox_pkg::NODES-1:0][7:0] node_type,
  input wire logic main_type_read,
  output logic main_interrupt_request,
  output logic [7:0] main_interrupt_type,
  output logic [mailbox_pkg::SOURCE_W-1:0] main_interrupt_source,
  output logic [mailbox_pkg::NODES-1:0] node_ack
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  mailbox_pkg::side_access_type local_acc0;
  mailbox_pkg::side_access_type local_acc1;
  mailbox_pkg::side_access_type remote_acc0;
  mailbox_pkg::side_access_type remote_acc1;

  wire logic [4:0] local_page = local_request.addr[7:3];
  wire logic [2:0] local_index = local_request.addr[2:0];
  wire logic [4:0] remote_page = remote_request.addr[7:3];
  wire logic [2:0] remote_index = remote_request.addr[2:0];

  wire logic local_in_range = local_index <= mailbox_pkg::IDX_BYTE3;
  wire logic remote_in_range = remote_index <= mailbox_pkg::IDX_BYTE3;

  wire logic local_hit0 = local_request.req & local_in_range &
                          (local_page == mailbox_pkg::PAGE_MB0);
  wire logic local_hit1 = local_request.req & local_in_range &
                          (local_page == mailbox_pkg::PAGE_MB1);
  // the host reaches the same mailbox pages through the bus-side address
  wire logic remote_hit0 = remote_request.req & remote_in_range &
                           (remote_page == mailbox_pkg::PAGE_MB0);
  wire logic remote_hit1 = remote_request.req & remote_in_range &
                           (remote_page == mailbox_pkg::PAGE_MB1);

  // the local type register is visible to the local processor only
  wire logic local_type_read = local_request.req & ~local_request.write &
                               (local_request.addr == mailbox_pkg::ADDR_LOCAL_TYPE);

  assign local_acc0 = '{write: local_hit0 & local_request.write,
                        read: local_hit0 & ~local_request.write,
                        index: local_index, wdata: local_request.wdata};
  assign local_acc1 = '{write: local_hit1 & local_request.write,
                        read: local_hit1 & ~local_request.write,
                        index: local_index, wdata: local_request.wdata};
  assign remote_acc0 = '{write: remote_hit0 & remote_request.write,
                         read: remote_hit0 & ~remote_request.write,
                         index: remote_index, wdata: remote_request.wdata};
  assign remote_acc1 = '{write: remote_hit1 & remote_request.write,
                         read: remote_hit1 & ~remote_request.write,
                         index: remote_index, wdata: remote_request.wdata};

  //////////////////////////////////////////////////////////////////////////////
  // the two mailboxes

  mailbox_pkg::control_type control0;
  mailbox_pkg::control_type control1;
  mailbox_pkg::status_type status0;
  mailbox_pkg::status_type status1;
  logic [7:0] mb0_local_rdata;
  logic [7:0] mb1_local_rdata;
  logic [7:0] mb0_remote_rdata;
  logic [7:0] mb1_remote_rdata;
  logic [mailbox_pkg::SOURCES-1:0] local_clear;
  logic [mailbox_pkg::SOURCES-1:0] host_clear;
  logic [mailbox_pkg::SOURCES-1:0] upstream_report;

  // both mailboxes share one design; only the reset direction differs
  mailbox_unit #(
    .RESET_DIR(mailbox_pkg::DIR_RECEIVE)
  ) first_mailbox (
    .clk(clk),
    .rstn(rstn),
    .host_acc(remote_acc0),
    .local_acc(local_acc0),
    .full_clear(local_clear[0] | host_clear[0]),
    .empty_clear(local_clear[1] | host_clear[1]),
    .control(control0),
    .status(status0),
    .host_rdata(mb0_remote_rdata),
    .local_rdata(mb0_local_rdata)
  );

  mailbox_unit #(
    .RESET_DIR(mailbox_pkg::DIR_TRANSMIT)
  ) second_mailbox (
    .clk(clk),
    .rstn(rstn),
    .host_acc(remote_acc1),
    .local_acc(local_acc1),
    .full_clear(local_clear[2] | host_clear[2]),
    .empty_clear(local_clear[3] | host_clear[3]),
    .control(control1),
    .status(status1),
    .host_rdata(mb1_remote_rdata),
    .local_rdata(mb1_local_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // interrupt routing: full goes to the reader, empty goes to the writer

  wire logic dir0 = control0.mailbox_direction_bit;
  wire logic dir1 = control1.mailbox_direction_bit;

  wire logic [mailbox_pkg::SOURCES-1:0] local_pending = {
    status1.empty_interrupt_flag & dir1,
    status1.full_interrupt_flag & ~dir1,
    status0.empty_interrupt_flag & dir0,
    status0.full_interrupt_flag & ~dir0
  };

  wire logic [mailbox_pkg::SOURCES-1:0] host_pending = {
    status1.empty_interrupt_flag & ~dir1,
    status1.full_interrupt_flag & dir1,
    status0.empty_interrupt_flag & ~dir0,
    status0.full_interrupt_flag & dir0
  };

  wire logic [mailbox_pkg::SOURCES-1:0] local_first = mailbox_pkg::lowest_one(local_pending);
  wire logic [mailbox_pkg::SOURCES-1:0] host_first = mailbox_pkg::lowest_one(host_pending);
  wire logic [7:0] local_type_code = mailbox_pkg::type_code(local_first);
  wire logic [7:0] host_type_code = mailbox_pkg::type_code(host_first);

  // reading the local type register counts as processing that interrupt
  assign local_clear = local_type_read ? local_first : '0;
  // the main side clears whatever we last reported upstream
  assign host_clear = upstream_ack ? upstream_report : '0;

  // rise only on a control frame; fall as soon as nothing is pending
  wire logic next_local_pin = (|local_pending) &
                              (interrupt_request_pin | downstream_control_frame);
  // rise only on a response frame, so delivery can lag up to one superframe
  wire logic next_upstream = (|host_pending) &
                             (upstream_irq_request | upstream_response_frame);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      interrupt_request_pin <= 1'b0;
      upstream_irq_request <= 1'b0;
      upstream_irq_type <= mailbox_pkg::TYPE_NONE;
      upstream_report <= '0;
    end
    else
    begin
      interrupt_request_pin <= next_local_pin;
      upstream_irq_request <= next_upstream;
      if (upstream_response_frame)
      begin
        upstream_report <= host_first;
        upstream_irq_type <= host_type_code;
      end
      else
      begin
        upstream_report <= upstream_report & ~host_clear;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read answers, one cycle after the request

  wire logic [7:0] next_local_rdata = local_hit0 ? mb0_local_rdata :
                                      local_hit1 ? mb1_local_rdata :
                                      local_type_read ? local_type_code :
                                      mailbox_pkg::READ_ZERO;
  wire logic [7:0] next_remote_rdata = remote_hit0 ? mb0_remote_rdata :
                                       remote_hit1 ? mb1_remote_rdata :
                                       mailbox_pkg::READ_ZERO;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      local_rdata <= mailbox_pkg::READ_ZERO;
      local_ack <= 1'b0;
      remote_rdata <= mailbox_pkg::READ_ZERO;
      remote_ack <= 1'b0;
    end
    else
    begin
      local_ack <= local_request.req;
      remote_ack <= remote_request.req;
      if (local_request.req && !local_request.write)
        local_rdata <= next_local_rdata;
      if (remote_request.req && !remote_request.write)
        remote_rdata <= next_remote_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // main-side reporting of subordinate requests

  main_interrupt_reporter reporter (
    .clk(clk),
    .rstn(rstn),
    .node_request(node_request),
    .node_type(node_type),
    .type_read(main_type_read),
    .main_irq(main_interrupt_request),
    .main_type(main_interrupt_type),
    .main_source(main_interrupt_source),
    .node_ack(node_ack)
  );

endmodule : interprocessor_mailbox_pair

// ---- verilog/mailbox_pkg.sv ----
// constants, field layouts and helpers shared by the mailbox pair and the
// main-side interrupt reporter. assumes every user sits on the single clk domain.
package mailbox_pkg;

  localparam int NODES = 4;
  localparam int SOURCE_W = 2;
  localparam int BYTES = 4;
  localparam int SOURCES = 4;

  // register index inside one mailbox page
  localparam logic [2:0] IDX_CTL = 3'h0;
  localparam logic [2:0] IDX_STAT = 3'h1;
  localparam logic [2:0] IDX_BYTE0 = 3'h2;
  localparam logic [2:0] IDX_BYTE3 = 3'h5;
  localparam logic [4:0] PAGE_MB0 = 5'h00;
  localparam logic [4:0] PAGE_MB1 = 5'h01;
  localparam logic [7:0] ADDR_LOCAL_TYPE = 8'h10;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'h3f;

  localparam logic DIR_RECEIVE = 1'b0;
  localparam logic DIR_TRANSMIT = 1'b1;
  localparam logic [1:0] LEN_RESET = 2'h0;

  localparam logic [7:0] TYPE_NONE = 8'h00;
  localparam logic [7:0] TYPE_MB0_FULL = 8'h10;
  localparam logic [7:0] TYPE_MB0_EMPTY = 8'h11;
  localparam logic [7:0] TYPE_MB1_FULL = 8'h12;
  localparam logic [7:0] TYPE_MB1_EMPTY = 8'h13;

  typedef struct packed {
    logic [1:0] reserved;
    logic empty_interrupt_enable;
    logic full_interrupt_enable;
    logic [1:0] message_length_field;
    logic mailbox_direction_bit;
    logic mailbox_enable_bit;
  } control_type;

  typedef struct packed {
    logic [1:0] reserved_hi;
    logic empty_interrupt_flag;
    logic full_interrupt_flag;
    logic [1:0] reserved_lo;
    logic empty_flag;
    logic full_flag;
  } status_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [2:0] index;
    logic [7:0] wdata;
  } side_access_type;

  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_request_type;

  function automatic logic [3:0] lowest_one(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction : lowest_one

  // source order: mb0 full, mb0 empty, mb1 full, mb1 empty
  function automatic logic [7:0] type_code(input logic [3:0] onehot);
    case (onehot)
      4'h1: return TYPE_MB0_FULL;
      4'h2: return TYPE_MB0_EMPTY;
      4'h4: return TYPE_MB1_FULL;
      4'h8: return TYPE_MB1_EMPTY;
      default: return TYPE_NONE;
    endcase
  endfunction : type_code

endpackage : mailbox_pkg

// ---- verilog/mailbox_unit.sv ----
// one mailbox: control, status, four data bytes and the full/empty flags.
// assumes at most one access per side per cycle, decoded by the parent.
`timescale 1ns/1ps
module mailbox_unit #(
  parameter logic RESET_DIR = mailbox_pkg::DIR_RECEIVE
) (
  input wire logic clk,
  input wire logic rstn,
  input mailbox_pkg::side_access_type host_acc,
  input mailbox_pkg::side_access_type local_acc,
  input wire logic full_clear,
  input wire logic empty_clear,
  output mailbox_pkg::control_type control,
  output mailbox_pkg::status_type status,
  output logic [7:0] host_rdata,
  output logic [7:0] local_rdata
);

  // unpacked, so that each byte slot has its own clocked process
  logic [7:0] data_byte [mailbox_pkg::BYTES];
  mailbox_pkg::side_access_type writer;
  mailbox_pkg::side_access_type reader;

  wire logic host_writes = control.mailbox_direction_bit == mailbox_pkg::DIR_RECEIVE;
  assign writer = host_writes ? host_acc : local_acc;
  assign reader = host_writes ? local_acc : host_acc;

  wire logic [2:0] final_index = 3'(mailbox_pkg::IDX_BYTE0 +
                                    {1'b0, control.message_length_field});
  // only the final byte of the owning side completes a message
  wire logic fill = control.mailbox_enable_bit & writer.write &
                    (writer.index == final_index);
  wire logic drain = control.mailbox_enable_bit & reader.read &
                     (reader.index == final_index);
  wire logic ctl_from_host = host_acc.write & (host_acc.index == mailbox_pkg::IDX_CTL);
  wire logic ctl_from_local = local_acc.write & (local_acc.index == mailbox_pkg::IDX_CTL);
  wire logic [7:0] ctl_wdata = ctl_from_host ? host_acc.wdata : local_acc.wdata;

  wire logic next_full = fill | (status.full_flag & ~drain);
  wire logic next_empty = ~fill & (drain | status.empty_flag);
  // a new event beats a clear in the same cycle
  wire logic next_firq = (fill & control.full_interrupt_enable) |
                         (status.full_interrupt_flag & ~full_clear);
  wire logic next_eirq = (drain & control.empty_interrupt_enable) |
                         (status.empty_interrupt_flag & ~empty_clear);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      control <= '{reserved: 2'h0, empty_interrupt_enable: 1'b0,
                   full_interrupt_enable: 1'b0,
                   message_length_field: mailbox_pkg::LEN_RESET,
                   mailbox_direction_bit: RESET_DIR, mailbox_enable_bit: 1'b0};
    end
    else if (ctl_from_host | ctl_from_local)
    begin
      // reconfiguring while enabled is left to software discipline
      control <= mailbox_pkg::control_type'(ctl_wdata & mailbox_pkg::CONTROL_MASK);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      status <= '{reserved_hi: 2'h0, empty_interrupt_flag: 1'b0,
                  full_interrupt_flag: 1'b0, reserved_lo: 2'h0,
                  empty_flag: 1'b1, full_flag: 1'b0};
    end
    else
    begin
      status.full_flag <= next_full;
      status.empty_flag <= next_empty;
      status.full_interrupt_flag <= next_firq;
      status.empty_interrupt_flag <= next_eirq;
    end
  end

  for (genvar i = 0; i < mailbox_pkg::BYTES; i++)
  begin : g_byte
    wire logic [2:0] slot = 3'(mailbox_pkg::IDX_BYTE0 + i);
    wire logic hw = host_acc.write & (host_acc.index == slot);
    wire logic lw = local_acc.write & (local_acc.index == slot);
    always_ff @(posedge clk)
    begin
      if (!rstn)
        data_byte[i] <= 8'h00;
      else if (hw)
        data_byte[i] <= host_acc.wdata;
      else if (lw)
        data_byte[i] <= local_acc.wdata;
    end
  end

  function automatic logic [7:0] read_reg(input logic [2:0] idx);
    if (idx == mailbox_pkg::IDX_CTL)
      return control;
    if (idx == mailbox_pkg::IDX_STAT)
      return status;
    if (idx >= mailbox_pkg::IDX_BYTE0 && idx <= mailbox_pkg::IDX_BYTE3)
      return data_byte[2'(idx - mailbox_pkg::IDX_BYTE0)];
    return mailbox_pkg::READ_ZERO;
  endfunction : read_reg

  // a plain assign would only wake on the index, missing flag updates
  // while the same register is polled
  always_comb
  begin
    host_rdata = read_reg(host_acc.index);
    local_rdata = read_reg(local_acc.index);
  end

endmodule : mailbox_unit

// ---- verilog/main_interrupt_reporter.sv ----
// main-side collector of subordinate interrupt requests; index 0 is the
// subordinate nearest the main node. requests come from same-clock link logic.
`timescale 1ns/1ps
module main_interrupt_reporter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [mailbox_pkg::NODES-1:0] node_request,
  input wire logic [mailbox_pkg::NODES-1:0][7:0] node_type,
  input wire logic type_read,
  output logic main_irq,
  output logic [7:0] main_type,
  output logic [mailbox_pkg::SOURCE_W-1:0] main_source,
  output logic [mailbox_pkg::NODES-1:0] node_ack
);

  logic [mailbox_pkg::NODES-1:0] acked;
  logic [mailbox_pkg::SOURCE_W-1:0] pick_index;

  // an acknowledged node is masked until its request actually falls,
  // since the clear reaches it only a frame later
  wire logic [mailbox_pkg::NODES-1:0] live = node_request & ~acked;
  wire logic [mailbox_pkg::NODES-1:0] pick = mailbox_pkg::lowest_one(live);
  wire logic acknowledge = type_read & main_irq;
  wire logic [mailbox_pkg::NODES-1:0] ack_onehot = 4'h1 << main_source;

  always_comb
  begin
    pick_index = '0;
    for (int i = mailbox_pkg::NODES - 1; i >= 0; i--)
      if (pick[i])
        pick_index = mailbox_pkg::SOURCE_W'(i);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      main_irq <= 1'b0;
      main_type <= mailbox_pkg::TYPE_NONE;
      main_source <= '0;
      node_ack <= '0;
      acked <= '0;
    end
    else
    begin
      node_ack <= acknowledge ? ack_onehot : '0;
      acked <= (acked & node_request) | (acknowledge ? ack_onehot : '0);
      main_irq <= ~acknowledge & (|live);
      if (!main_irq)
      begin
        main_type <= (|live) ? node_type[pick_index] : mailbox_pkg::TYPE_NONE;
        main_source <= pick_index;
      end
    end
  end

endmodule : main_interrupt_reporter

// ---- tb/interprocessor_mailbox_pair_sva.sv ----
// checker for the mailbox pair top: ack timing, frame alignment, main reporter.
// assumes node_request and node_type stay put while a request is reported.
`timescale 1ns/1ps
module interprocessor_mailbox_pair_sva (
  input wire logic clk,
  input wire logic rstn,
  input mailbox_pkg::bus_request_type local_request,
  input wire logic local_ack,
  input mailbox_pkg::bus_request_type remote_request,
  input wire logic remote_ack,
  input wire logic downstream_control_frame,
  input wire logic upstream_response_frame,
  input wire logic interrupt_request_pin,
  input wire logic upstream_irq_request,
  input wire logic [3:0] node_request,
  input wire logic [3:0][7:0] node_type,
  input wire logic main_type_read,
  input wire logic main_interrupt_request,
  input wire logic [7:0] main_interrupt_type,
  input wire logic [1:0] main_interrupt_source,
  input wire logic [3:0] node_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  sequence acked_read_s;
    main_type_read && main_interrupt_request;
  endsequence
  sequence dip_s;
    !main_interrupt_request ##1 main_interrupt_request;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  local_ack_a: assert property (local_ack == $past(local_request.req))
    else $error("local ack not one cycle after request");
  remote_ack_a: assert property (remote_request.req |=> remote_ack)
    else $error("remote ack missing");
  pin_frame_a: assert property ($rose(interrupt_request_pin) |-> $past(downstream_control_frame))
    else $error("local pin rose off a control frame");
  up_frame_a: assert property ($rose(upstream_irq_request) |-> $past(upstream_response_frame))
    else $error("upstream request rose off a response frame");
  main_clear_a: assert property (acked_read_s |=> !main_interrupt_request
    && node_ack == (4'h1 << $past(main_interrupt_source)))
    else $error("type read did not clear the named node");
  ack_cause_a: assert property (|node_ack |-> $past(main_type_read && main_interrupt_request))
    else $error("node ack without a type read");
  reassert_a: assert property (acked_read_s
    and (|(node_request & ~(4'h1 << main_interrupt_source))) |=> dip_s)
    else $error("main request did not dip and return");
  main_type_a: assert property ($rose(main_interrupt_request)
    |-> main_interrupt_type == node_type[main_interrupt_source])
    else $error("main type does not match source node");
  main_idle_a: assert property (!(|node_request) |=> !main_interrupt_request)
    else $error("main request with no node live");
endmodule : interprocessor_mailbox_pair_sva

bind interprocessor_mailbox_pair interprocessor_mailbox_pair_sva sva_i (.clk(clk), .rstn(rstn),
  .local_request(local_request), .local_ack(local_ack), .remote_request(remote_request),
  .remote_ack(remote_ack), .downstream_control_frame(downstream_control_frame),
  .upstream_response_frame(upstream_response_frame),
  .interrupt_request_pin(interrupt_request_pin), .upstream_irq_request(upstream_irq_request),
  .node_request(node_request), .node_type(node_type), .main_type_read(main_type_read),
  .main_interrupt_request(main_interrupt_request), .main_interrupt_type(main_interrupt_type),
  .main_interrupt_source(main_interrupt_source), .node_ack(node_ack));

// ---- tb/link_frame_partner.sv ----
// far side of the link: frame strobes every 16 cycles, main-side ack of upstream requests.
// assumes the same clk as the mailbox pair.
`timescale 1ns/1ps
module link_frame_partner (
  input wire logic clk,
  input wire logic rstn,
  input wire logic upstream_irq_request,
  output logic downstream_control_frame = 1'b0,
  output logic upstream_response_frame = 1'b0,
  output logic upstream_ack = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // ack lands well after the response frame, as a host read would
  always @(posedge clk)
  begin
    cnt <= rstn ? cnt + 4'h1 : 4'h0;
    downstream_control_frame <= rstn && cnt == 4'h3;
    upstream_response_frame <= rstn && cnt == 4'hb;
    upstream_ack <= rstn && cnt == 4'h3 && upstream_irq_request;
  end
endmodule : link_frame_partner

// ---- tb/interprocessor_mailbox_pair_tb.sv ----
// self-checking bench for the mailbox pair; reads are checked from expectation queues.
// assumes link_frame_partner supplies frames and upstream acks.
`timescale 1ns/1ps
module interprocessor_mailbox_pair_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  mailbox_pkg::bus_request_type local_request = '0;
  mailbox_pkg::bus_request_type remote_request = '0;
  logic [7:0] local_rdata, remote_rdata;
  logic local_ack, remote_ack, frame_c, frame_r, up_ack, interrupt_request_pin;
  logic upstream_irq_request, main_interrupt_request, main_type_read = 1'b0;
  logic [7:0] upstream_irq_type, main_interrupt_type;
  logic [1:0] main_interrupt_source;
  logic [3:0] node_request = 4'h0, node_ack;
  logic [3:0][7:0] node_type;
  logic [8:0] lq[$], rq[$], e;
  logic [7:0] mem[4];
  int n_errors = 0, check_count = 0, seed = 19;

  initial forever #2.5 clk = ~clk;

  interprocessor_mailbox_pair dut (.clk(clk), .rstn(rstn), .local_request(local_request),
    .local_rdata(local_rdata), .local_ack(local_ack), .remote_request(remote_request),
    .remote_rdata(remote_rdata), .remote_ack(remote_ack), .downstream_control_frame(frame_c),
    .upstream_response_frame(frame_r), .upstream_ack(up_ack),
    .interrupt_request_pin(interrupt_request_pin), .upstream_irq_request(upstream_irq_request),
    .upstream_irq_type(upstream_irq_type), .node_request(node_request), .node_type(node_type),
    .main_type_read(main_type_read), .main_interrupt_request(main_interrupt_request),
    .main_interrupt_type(main_interrupt_type), .main_interrupt_source(main_interrupt_source),
    .node_ack(node_ack));
  link_frame_partner partner (.clk(clk), .rstn(rstn), .upstream_irq_request(upstream_irq_request),
    .downstream_control_frame(frame_c), .upstream_response_frame(frame_r), .upstream_ack(up_ack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // s=1 host port; x[8] set means compare the read data with x[7:0]
  task automatic acc(input bit s, input bit w, input logic [7:0] a, d, input logic [8:0] x);
    @(posedge clk);
    if (s) remote_request <= '{1'b1, w, a, d};
    else local_request <= '{1'b1, w, a, d};
    if (s) rq.push_back(x);
    else lq.push_back(x);
    @(posedge clk);
    if (s) remote_request.req <= 1'b0;
    else local_request.req <= 1'b0;
    @(posedge clk);
  endtask : acc

  task automatic wait_for(input bit k, input bit v);
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if ((k ? upstream_irq_request : interrupt_request_pin) === v) break;
    end
    if (i == 100) check(8'h00, 8'h01);
  endtask : wait_for

  task automatic run_msg(input bit p, input bit dir, input logic [1:0] len);
    logic [7:0] b, code;
    b = {4'h0, p, 3'h0};
    code = mailbox_pkg::TYPE_MB0_FULL + {6'h0, p, 1'b0};
    acc(1, 1, b, {2'b00, 1'b1, 1'b1, len, dir, 1'b1}, 9'h0);
    for (int i = 0; i <= len; i++)
    begin
      mem[i] = 8'($random(seed));
      acc(!dir, 1, b + 8'h2 + 8'(i), mem[i], 9'h0);
      if (i < len) acc(0, 0, b + 8'h1, 8'h0, 9'h102);
    end
    acc(0, 0, b + 8'h1, 8'h0, 9'h111);
    wait_for(dir, 1'b1);
    if (dir) check(upstream_irq_type, code);
    else acc(0, 0, 8'h10, 8'h0, {1'b1, code});
    if (dir) wait_for(1, 1'b0);
    for (int i = 0; i <= len; i++)
      acc(dir, 0, b + 8'h2 + 8'(i), 8'h0, {1'b1, mem[i]});
    acc(1, 0, b + 8'h1, 8'h0, 9'h122);
    wait_for(!dir, 1'b1);
    if (dir) acc(0, 0, 8'h10, 8'h0, {1'b1, code + 8'h1});
    else check(upstream_irq_type, code + 8'h1);
    wait_for(!dir, 1'b0);
    acc(1, 1, b, 8'h0, 9'h0);
  endtask : run_msg
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (local_ack === 1'b1)
    begin
      e = lq.pop_front();
      if (e[8]) check(local_rdata, e[7:0]);
    end
    if (remote_ack === 1'b1)
    begin
      e = rq.pop_front();
      if (e[8]) check(remote_rdata, e[7:0]);
    end
  end

  initial
  begin
    #100000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    for (int i = 0; i < 4; i++) node_type[i] = 8'($random(seed)) | 8'h01;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    acc(0, 0, 8'h00, 8'h0, 9'h100);
    acc(0, 0, 8'h08, 8'h0, 9'h102);
    acc(1, 0, 8'h09, 8'h0, 9'h102);
    acc(1, 0, 8'h1f, 8'h0, 9'h100);
    for (int p = 0; p < 2; p++)
      for (int n = 0; n < 4; n++) run_msg(p[0], p[0], n[1:0]);
    run_msg(0, 1, 2'h3);
    run_msg(1, 0, 2'h0);
    @(posedge clk) node_request <= 4'ha;
    repeat (4) @(posedge clk);
    check({7'h0, main_interrupt_request}, 8'h01);
    check({6'h0, main_interrupt_source}, 8'h01);
    check(main_interrupt_type, node_type[1]);
    main_type_read <= 1'b1;
    @(posedge clk);
    main_type_read <= 1'b0;
    node_request <= 4'h8;
    repeat (3) @(posedge clk);
    check({6'h0, main_interrupt_source}, 8'h03);
    check(main_interrupt_type, node_type[3]);
    main_type_read <= 1'b1;
    @(posedge clk);
    main_type_read <= 1'b0;
    node_request <= 4'h0;
    repeat (3) @(posedge clk);
    check({7'h0, main_interrupt_request}, 8'h00);
    give_verdict();
  end
endmodule : interprocessor_mailbox_pair_tb
